// File: rtl/pwrseq_pkg.sv
// Constants for the microcontroller rail power-up sequencer.
// Assumes a 20 MHz reference clock; all times are derived from it.
package pwrseq_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int INIT_TIME_MS = 6;
    localparam int STRAP_TIME_MS = 2;
    localparam int PG_CHECK_TIME_MS = 10;
    localparam int DEGLITCH_TIME_US = 125;
    localparam int INIT_CYCLES = CLK_HZ / 1000 * INIT_TIME_MS;
    localparam int STRAP_CYCLES = CLK_HZ / 1000 * STRAP_TIME_MS;
    localparam int PG_CHECK_CYCLES = CLK_HZ / 1000 * PG_CHECK_TIME_MS;
    localparam int DEGLITCH_CYCLES = CLK_HZ / 1_000_000 * DEGLITCH_TIME_US;
    localparam int CNT_W = 24;
    localparam int DG_W = 12;

    // ------------------------------------------------------------
    // Strap input classes and rail voltage codes
    // ------------------------------------------------------------
    localparam logic [1:0] STRAP_R620_GND = 2'h0;
    localparam logic [1:0] STRAP_SHORT_GND = 2'h1;
    localparam logic [1:0] STRAP_SHORT_INTERNAL_CORE_RAIL = 2'h2;
    localparam logic [1:0] STRAP_C330_GND = 2'h3;
    localparam logic [1:0] VSEL_1V5 = 2'h0;
    localparam logic [1:0] VSEL_1V8 = 2'h1;
    localparam logic [1:0] VSEL_2V5 = 2'h2;
    localparam logic [1:0] VSEL_3V3 = 2'h3;
    localparam logic [1:0] VSEL_RESET = VSEL_1V8;

    typedef enum logic [2:0] {
        ST_WAIT_SUPPLY = 3'h0,
        ST_INIT = 3'h1,
        ST_STRAP = 3'h3,
        ST_ENABLE = 3'h2,
        ST_RUN = 3'h6,
        ST_FAULT = 3'h7
    } seq_state_t;

endpackage : pwrseq_pkg

// File: rtl/pg_deglitch.sv
// Deglitch filter for the rail power-good comparator.
// Input is synchronised by the caller; output changes only after a stable run.
`timescale 1ns/1ns
module pg_deglitch #(
    parameter int STABLE_CYCLES = pwrseq_pkg::DEGLITCH_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_level,
    output logic o_level
);
    logic [pwrseq_pkg::DG_W-1:0] cnt_reg;
    logic [pwrseq_pkg::DG_W-1:0] cnt_next;
    logic level_reg;
    logic level_next;

    always_comb
    begin
        cnt_next = '0;
        level_next = level_reg;
        if (i_level != level_reg)
        begin
            if (cnt_reg == pwrseq_pkg::DG_W'(STABLE_CYCLES - 1))
                level_next = i_level;
            else
                cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_reg <= '0;
            level_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            level_reg <= level_next;
        end
    end

    assign o_level = level_reg;

    // Short pulses never reach the output
    pg_filter_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $changed(level_reg) |-> $past(i_level, STABLE_CYCLES) == level_reg)
        else $error("power-good changed without a stable input run");
endmodule : pg_deglitch

// File: rtl/mcu_supply_powerup_sequencer.sv
// Power-up sequencer and supervisor for the microcontroller rail regulator.
// Assumes analog comparators and strap classifier deliver asynchronous levels.
`timescale 1ns/1ns
module mcu_supply_powerup_sequencer #(
    parameter int INIT_CYCLES = pwrseq_pkg::INIT_CYCLES,
    parameter int STRAP_CYCLES = pwrseq_pkg::STRAP_CYCLES,
    parameter int PG_CHECK_CYCLES = pwrseq_pkg::PG_CHECK_CYCLES,
    parameter int DEGLITCH_CYCLES = pwrseq_pkg::DEGLITCH_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_power_up_threshold,
    input wire logic [1:0] i_rail_voltage_strap,
    input wire logic i_mcu_rail_pg_raw,
    input wire logic [1:0] i_mcu_rail_voltage_select,
    input wire logic i_mcu_rail_voltage_write,
    input wire logic i_mcu_rail_disable,
    input wire logic i_mcu_rail_error_mask,
    output logic o_mcu_rail_regulator_en,
    output logic [1:0] o_mcu_rail_voltage_select,
    output logic o_mcu_rail_power_good,
    output logic o_mcu_rail_error,
    output logic o_rail_fault,
    output logic o_serial_bus_allowed,
    output logic o_internal_core_regulator_en,
    output logic [2:0] o_state
);
    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Three stages; a change is taken once stages two and three agree
    logic [2:0] sup_sync_reg;
    logic [2:0] pg_sync_reg;
    logic [1:0] strap_s1_reg;
    logic [1:0] strap_s2_reg;
    logic [1:0] strap_s3_reg;
    logic sup_level_reg;
    logic pg_level_reg;
    logic [1:0] strap_level_reg;

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sup_sync_reg <= 3'h0;
            pg_sync_reg <= 3'h0;
            strap_s1_reg <= 2'h0;
            strap_s2_reg <= 2'h0;
            strap_s3_reg <= 2'h0;
            sup_level_reg <= 1'b0;
            pg_level_reg <= 1'b0;
            strap_level_reg <= 2'h0;
        end
        else
        begin
            sup_sync_reg <= {sup_sync_reg[1:0], i_power_up_threshold};
            pg_sync_reg <= {pg_sync_reg[1:0], i_mcu_rail_pg_raw};
            strap_s1_reg <= i_rail_voltage_strap;
            strap_s2_reg <= strap_s1_reg;
            strap_s3_reg <= strap_s2_reg;
            if (sup_sync_reg[1] == sup_sync_reg[2])
                sup_level_reg <= sup_sync_reg[2];
            if (pg_sync_reg[1] == pg_sync_reg[2])
                pg_level_reg <= pg_sync_reg[2];
            if (strap_s2_reg == strap_s3_reg)
                strap_level_reg <= strap_s3_reg;
        end
    end

    // ------------------------------------------------------------
    // Power-good deglitch
    // ------------------------------------------------------------
    logic pg_clean;

    pg_deglitch #(
        .STABLE_CYCLES(DEGLITCH_CYCLES)
    ) u_pg_deglitch (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_level(pg_level_reg),
        .o_level(pg_clean)
    );

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    function automatic logic [1:0] strap_to_vsel(input logic [1:0] strap);
        case (strap)
            pwrseq_pkg::STRAP_R620_GND: strap_to_vsel = pwrseq_pkg::VSEL_1V5;
            pwrseq_pkg::STRAP_SHORT_GND: strap_to_vsel = pwrseq_pkg::VSEL_1V8;
            pwrseq_pkg::STRAP_SHORT_INTERNAL_CORE_RAIL: strap_to_vsel = pwrseq_pkg::VSEL_2V5;
            default: strap_to_vsel = pwrseq_pkg::VSEL_3V3;
        endcase
    endfunction : strap_to_vsel

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    pwrseq_pkg::seq_state_t state_reg;
    pwrseq_pkg::seq_state_t state_next;
    logic [pwrseq_pkg::CNT_W-1:0] cnt_reg;
    logic [pwrseq_pkg::CNT_W-1:0] cnt_next;
    logic err_reg;
    logic err_next;
    logic [1:0] vsel_reg;
    logic [1:0] vsel_next;
    logic bus_ok_reg;
    logic bus_ok_next;
    logic en_reg;
    logic en_next;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        vsel_next = vsel_reg;
        bus_ok_next = bus_ok_reg;
        en_next = en_reg;
        case (state_reg)
            pwrseq_pkg::ST_WAIT_SUPPLY:
            begin
                cnt_next = '0;
                if (sup_level_reg)
                    state_next = pwrseq_pkg::ST_INIT;
            end
            pwrseq_pkg::ST_INIT:
            begin
                if (cnt_reg == pwrseq_pkg::CNT_W'(INIT_CYCLES - 1))
                begin
                    cnt_next = '0;
                    state_next = pwrseq_pkg::ST_STRAP;
                end
                else
                    cnt_next = cnt_reg + 1'b1;
            end
            pwrseq_pkg::ST_STRAP:
            begin
                // Last stable sample of the window wins
                if (cnt_reg == pwrseq_pkg::CNT_W'(STRAP_CYCLES - 1))
                begin
                    cnt_next = '0;
                    vsel_next = strap_to_vsel(strap_level_reg);
                    state_next = pwrseq_pkg::ST_ENABLE;
                end
                else
                    cnt_next = cnt_reg + 1'b1;
            end
            pwrseq_pkg::ST_ENABLE:
            begin
                en_next = 1'b1;
                if (pg_clean)
                begin
                    bus_ok_next = 1'b1;
                    state_next = pwrseq_pkg::ST_RUN;
                end
            end
            pwrseq_pkg::ST_RUN:
            begin
                if (i_mcu_rail_voltage_write)
                    vsel_next = i_mcu_rail_voltage_select;
                en_next = !i_mcu_rail_disable;
            end
            pwrseq_pkg::ST_FAULT:
            begin
                // Regulator held off until reset, supply loss or error mask set
                en_next = 1'b0;
                if (i_mcu_rail_error_mask)
                    state_next = pwrseq_pkg::ST_RUN;
            end
            default:
                state_next = pwrseq_pkg::ST_WAIT_SUPPLY;
        endcase
        if (state_reg != pwrseq_pkg::ST_WAIT_SUPPLY && !sup_level_reg)
        begin
            state_next = pwrseq_pkg::ST_WAIT_SUPPLY;
            en_next = 1'b0;
            bus_ok_next = 1'b0;
            cnt_next = '0;
        end
        else if (err_reg && !i_mcu_rail_error_mask && state_reg != pwrseq_pkg::ST_WAIT_SUPPLY)
            state_next = pwrseq_pkg::ST_FAULT;
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= pwrseq_pkg::ST_WAIT_SUPPLY;
            cnt_reg <= '0;
            vsel_reg <= pwrseq_pkg::VSEL_RESET;
            bus_ok_reg <= 1'b0;
            en_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            vsel_reg <= vsel_next;
            bus_ok_reg <= bus_ok_next;
            en_reg <= en_next;
        end
    end

    // ------------------------------------------------------------
    // Power-good check timer and rail error flag
    // ------------------------------------------------------------
    logic chk_run_reg;
    logic chk_run_next;
    logic [pwrseq_pkg::CNT_W-1:0] chk_cnt_reg;
    logic [pwrseq_pkg::CNT_W-1:0] chk_cnt_next;
    logic rail_event;

    assign rail_event = (en_next && !en_reg) || (en_reg && vsel_next != vsel_reg);

    always_comb
    begin
        err_next = err_reg;
        chk_run_next = chk_run_reg;
        chk_cnt_next = chk_cnt_reg;
        if (rail_event)
        begin
            chk_run_next = 1'b1;
            chk_cnt_next = '0;
        end
        else if (chk_run_reg)
        begin
            if (pg_clean || !en_reg)
                chk_run_next = 1'b0;
            else if (chk_cnt_reg == pwrseq_pkg::CNT_W'(PG_CHECK_CYCLES - 1))
            begin
                err_next = 1'b1;
                chk_run_next = 1'b0;
            end
            else
                chk_cnt_next = chk_cnt_reg + 1'b1;
        end
        // Supply loss clears the flag at the same edge as the state
        if (state_next == pwrseq_pkg::ST_WAIT_SUPPLY)
            err_next = 1'b0;
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_reg <= 1'b0;
            chk_run_reg <= 1'b0;
            chk_cnt_reg <= '0;
        end
        else
        begin
            err_reg <= err_next;
            chk_run_reg <= chk_run_next;
            chk_cnt_reg <= chk_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_mcu_rail_regulator_en = en_reg;
    assign o_mcu_rail_voltage_select = vsel_reg;
    assign o_mcu_rail_power_good = pg_clean;
    assign o_mcu_rail_error = err_reg;
    assign o_rail_fault = (state_reg == pwrseq_pkg::ST_FAULT);
    assign o_serial_bus_allowed = bus_ok_reg;
    assign o_internal_core_regulator_en = 1'b1;
    assign o_state = state_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    init_wait_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        $rose(state_reg == pwrseq_pkg::ST_STRAP) |-> $past(state_reg, INIT_CYCLES) == pwrseq_pkg::ST_INIT)
        else $error("strap phase began before the init period ended");
    strap_window_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        $rose(state_reg == pwrseq_pkg::ST_ENABLE) |-> $past(state_reg, STRAP_CYCLES) == pwrseq_pkg::ST_STRAP)
        else $error("strap window length wrong");
    strap_decode_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        $rose(state_reg == pwrseq_pkg::ST_ENABLE) |-> vsel_reg == strap_to_vsel($past(strap_level_reg)))
        else $error("rail setting does not match strap");
    enable_after_strap_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        state_reg == pwrseq_pkg::ST_ENABLE && sup_level_reg && !err_reg |=> en_reg)
        else $error("regulator not enabled after strap decode");
    bus_gate_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        $rose(bus_ok_reg) |-> $past(pg_clean))
        else $error("serial bus allowed before power-good");
    sw_vsel_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        state_reg == pwrseq_pkg::ST_RUN && i_mcu_rail_voltage_write && sup_level_reg
        |=> vsel_reg == $past(i_mcu_rail_voltage_select))
        else $error("software voltage write not taken");
    disable_off_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        i_mcu_rail_disable && state_reg == pwrseq_pkg::ST_RUN |=> !en_reg)
        else $error("regulator still on after disable");
    pg_timeout_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        $rose(err_reg) |-> $past(chk_cnt_reg) == pwrseq_pkg::CNT_W'(PG_CHECK_CYCLES - 1) && !$past(pg_clean))
        else $error("rail error set without a full check period");
    fault_entry_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        err_reg && !i_mcu_rail_error_mask && sup_level_reg && state_reg != pwrseq_pkg::ST_WAIT_SUPPLY
        |=> o_rail_fault)
        else $error("fault state not entered on unmasked rail error");
    core_on_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        o_internal_core_regulator_en)
        else $error("core regulator switched off");
    chk_stop_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        chk_run_reg && pg_clean && !rail_event |=> !chk_run_reg && $stable(err_reg))
        else $error("check timer kept running after power-good");
endmodule : mcu_supply_powerup_sequencer

// File: bench/rail_model.sv
// Behavioural rail and power-good comparator beside the sequencer.
// Assumes the sequencer clock; the bench picks the rail behaviour.
`timescale 1ns/1ns
module rail_model #(
    parameter int RISE_CYCLES = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_regulator_en,
    input wire logic [1:0] i_mode,
    output logic o_pg_raw
);
    logic [7:0] ramp_reg;
    logic [7:0] ramp_next;

    // Saturates so a long run never fakes a rail drop
    always_comb
    begin
        ramp_next = 8'h00;
        if (i_regulator_en && ramp_reg != 8'hFF)
        begin
            ramp_next = ramp_reg + 8'h01;
        end
        else if (i_regulator_en)
        begin
            ramp_next = ramp_reg;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        ramp_reg <= ramp_next;
    end

    // Mode 0 good rail, 1 dead rail, 2 spikes shorter than the filter
    always_comb
    begin
        case (i_mode)
            2'h0: o_pg_raw = i_regulator_en && (ramp_reg >= 8'(RISE_CYCLES));
            2'h2: o_pg_raw = i_regulator_en && (ramp_reg[3:0] < 4'h2);
            default: o_pg_raw = 1'b0;
        endcase
    end
endmodule : rail_model

// File: bench/tb_mcu_supply_powerup_sequencer.sv
// Self-checking bench for the rail power-up sequencer.
// Assumes shortened counts; a rail model answers the regulator enable.
`timescale 1ns/1ns
module tb_mcu_supply_powerup_sequencer;
    localparam int INIT_C = 20;
    localparam int STRAP_C = 10;
    localparam int CHECK_C = 50;
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_power_up_threshold = 1'b0;
    logic [1:0] i_rail_voltage_strap = 2'h0;
    logic i_mcu_rail_pg_raw;
    logic [1:0] i_mcu_rail_voltage_select = 2'h0;
    logic i_mcu_rail_voltage_write = 1'b0;
    logic i_mcu_rail_disable = 1'b0;
    logic i_mcu_rail_error_mask = 1'b0;
    logic o_mcu_rail_regulator_en;
    logic [1:0] o_mcu_rail_voltage_select;
    logic o_mcu_rail_power_good;
    logic o_mcu_rail_error;
    logic o_rail_fault;
    logic o_serial_bus_allowed;
    logic o_internal_core_regulator_en;
    logic [2:0] o_state;
    logic [1:0] rail_mode = 2'h0;
    logic [1:0] decode [4];
    logic [1:0] exp_q [$];
    logic [1:0] code;
    logic en_prev = 1'b0;
    logic [1:0] vsel_prev = 2'h1;
    int n_fail = 0;
    int n_compared = 0;
    integer seed = 81285;

    mcu_supply_powerup_sequencer #(.INIT_CYCLES(INIT_C), .STRAP_CYCLES(STRAP_C),
        .PG_CHECK_CYCLES(CHECK_C), .DEGLITCH_CYCLES(5)) mcu_supply_powerup_sequencer_i (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_power_up_threshold(i_power_up_threshold),
        .i_rail_voltage_strap(i_rail_voltage_strap), .i_mcu_rail_pg_raw(i_mcu_rail_pg_raw),
        .i_mcu_rail_voltage_select(i_mcu_rail_voltage_select), .i_mcu_rail_voltage_write(i_mcu_rail_voltage_write),
        .i_mcu_rail_disable(i_mcu_rail_disable), .i_mcu_rail_error_mask(i_mcu_rail_error_mask),
        .o_mcu_rail_regulator_en(o_mcu_rail_regulator_en), .o_mcu_rail_voltage_select(o_mcu_rail_voltage_select),
        .o_mcu_rail_power_good(o_mcu_rail_power_good), .o_mcu_rail_error(o_mcu_rail_error),
        .o_rail_fault(o_rail_fault), .o_serial_bus_allowed(o_serial_bus_allowed),
        .o_internal_core_regulator_en(o_internal_core_regulator_en), .o_state(o_state));

    rail_model rail_model_i (.i_ref_clk(i_ref_clk), .i_regulator_en(o_mcu_rail_regulator_en),
        .i_mode(rail_mode), .o_pg_raw(i_mcu_rail_pg_raw));

    initial
    begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    // ------------------------------------------------------------
    // Compare, wait and closing tasks
    // ------------------------------------------------------------
    task automatic check_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_vec(input string what, input logic [2:0] exp, input logic [2:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_vec

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask : tick

    task automatic wait_state(input logic [2:0] st, input int lim);
        int k;
        k = 0;
        while (o_state !== st && k < lim)
        begin
            tick(1);
            k++;
        end
        check_vec("state", st, o_state);
        if (o_state !== st)
            wrap_up();
    endtask : wait_state

    task automatic wait_error(input int lim);
        int k;
        k = 0;
        while (o_mcu_rail_error !== 1'b1 && k < lim)
        begin
            tick(1);
            k++;
        end
        check_bit("rail_error", 1'b1, o_mcu_rail_error);
        if (o_mcu_rail_error !== 1'b1)
            wrap_up();
    endtask : wait_error

    task automatic power_up(input logic [1:0] strap, input logic [1:0] mode);
        int k;
        k = 0;
        i_rail_voltage_strap = strap;
        rail_mode = mode;
        exp_q.push_back(decode[strap]);
        i_power_up_threshold = 1'b1;
        while (o_mcu_rail_regulator_en !== 1'b1 && k < 200)
        begin
            tick(1);
            k++;
        end
        check_bit("enable_delay", 1'b1, k >= INIT_C + STRAP_C && k <= INIT_C + STRAP_C + 12);
        check_bit("bus_before_good", 1'b0, o_serial_bus_allowed);
        check_bit("core_enable", 1'b1, o_internal_core_regulator_en);
    endtask : power_up

    task automatic power_down();
        i_power_up_threshold = 1'b0;
        wait_state(pwrseq_pkg::ST_WAIT_SUPPLY, 20);
        check_bit("enable_off", 1'b0, o_mcu_rail_regulator_en);
        check_bit("bus_off", 1'b0, o_serial_bus_allowed);
        check_bit("error_off", 1'b0, o_mcu_rail_error);
        rail_mode = 2'h0;
        tick(3);
    endtask : power_down

    // ------------------------------------------------------------
    // Watcher: each new voltage setting takes the oldest note
    // ------------------------------------------------------------
    always @(posedge i_ref_clk)
    begin
        if ((o_mcu_rail_regulator_en === 1'b1 && en_prev !== 1'b1 && o_state === pwrseq_pkg::ST_ENABLE) ||
            (o_state === pwrseq_pkg::ST_RUN && o_mcu_rail_voltage_select !== vsel_prev))
        begin
            if (exp_q.size() == 0)
                check_vec("voltage_select_unexpected", {1'b0, vsel_prev}, {1'b0, o_mcu_rail_voltage_select});
            else
                check_vec("voltage_select", {1'b0, exp_q.pop_front()}, {1'b0, o_mcu_rail_voltage_select});
        end
        en_prev <= o_mcu_rail_regulator_en;
        vsel_prev <= o_mcu_rail_voltage_select;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        decode[pwrseq_pkg::STRAP_R620_GND] = pwrseq_pkg::VSEL_1V5;
        decode[pwrseq_pkg::STRAP_SHORT_GND] = pwrseq_pkg::VSEL_1V8;
        decode[pwrseq_pkg::STRAP_SHORT_INTERNAL_CORE_RAIL] = pwrseq_pkg::VSEL_2V5;
        decode[pwrseq_pkg::STRAP_C330_GND] = pwrseq_pkg::VSEL_3V3;
        tick(4);
        i_reset_n = 1'b1;
        tick(3);
        check_vec("reset_voltage", {1'b0, pwrseq_pkg::VSEL_RESET}, {1'b0, o_mcu_rail_voltage_select});
        check_bit("reset_core_enable", 1'b1, o_internal_core_regulator_en);
        check_bit("reset_enable", 1'b0, o_mcu_rail_regulator_en);
        $display("test reset done");
        for (int c = 0; c < 4; c++)
        begin
            power_up(2'(c), 2'h0);
            wait_state(pwrseq_pkg::ST_RUN, 60);
            check_bit("bus_allowed", 1'b1, o_serial_bus_allowed);
            check_bit("power_good", 1'b1, o_mcu_rail_power_good);
            power_down();
        end
        $display("test strap decode done");
        power_up(2'($random(seed)), 2'h0);
        wait_state(pwrseq_pkg::ST_RUN, 60);
        code = o_mcu_rail_voltage_select;
        i_mcu_rail_voltage_write = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            i_mcu_rail_voltage_select = 2'($random(seed));
            if (i_mcu_rail_voltage_select != code)
                exp_q.push_back(i_mcu_rail_voltage_select);
            code = i_mcu_rail_voltage_select;
            tick(1);
        end
        i_mcu_rail_voltage_write = 1'b0;
        tick(CHECK_C + 20);
        check_vec("final_voltage", {1'b0, code}, {1'b0, o_mcu_rail_voltage_select});
        check_bit("no_error_after_writes", 1'b0, o_mcu_rail_error);
        $display("test reprogram done");
        i_mcu_rail_disable = 1'b1;
        tick(3);
        check_bit("disabled", 1'b0, o_mcu_rail_regulator_en);
        tick(CHECK_C + 10);
        check_bit("no_error_while_off", 1'b0, o_mcu_rail_error);
        i_mcu_rail_disable = 1'b0;
        tick(CHECK_C + 20);
        check_bit("reenabled", 1'b1, o_mcu_rail_regulator_en);
        check_bit("no_error_after_enable", 1'b0, o_mcu_rail_error);
        power_down();
        $display("test disable done");
        power_up(2'($random(seed)), 2'h1);
        tick(CHECK_C - 8);
        check_bit("error_early", 1'b0, o_mcu_rail_error);
        wait_error(20);
        tick(2);
        check_vec("fault_state", pwrseq_pkg::ST_FAULT, o_state);
        check_bit("fault_flag", 1'b1, o_rail_fault);
        check_bit("fault_enable", 1'b0, o_mcu_rail_regulator_en);
        i_mcu_rail_error_mask = 1'b1;
        wait_state(pwrseq_pkg::ST_RUN, 10);
        check_bit("fault_cleared", 1'b0, o_rail_fault);
        power_down();
        $display("test dead rail done");
        power_up(2'($random(seed)), 2'h2);
        wait_error(CHECK_C + 20);
        check_bit("spikes_filtered", 1'b0, o_mcu_rail_power_good);
        check_bit("masked_fault", 1'b0, o_rail_fault);
        power_down();
        i_mcu_rail_error_mask = 1'b0;
        $display("test glitch rail done");
        check_bit("queue_drained", 1'b1, exp_q.size() == 0);
        wrap_up();
    end
endmodule : tb_mcu_supply_powerup_sequencer
